// ---- inc/slt_pkg.sv ----
// Purpose: Shared constants and types of the STN panel timing and fetch block.
// Assumes: Single core clock at 20 MHz.
// Notes: Scan codes are also the encoding of the scan_mode port.
package slt_pkg;

	// ****************************************
	// Scan formats
	// ****************************************
	localparam logic [1:0] SCAN_SINGLE4 = 2'h0;
	localparam logic [1:0] SCAN_SINGLE8 = 2'h1;
	localparam logic [1:0] SCAN_DUAL4 = 2'h2;

	// ****************************************
	// Clocking and divisor limits
	// ****************************************
	localparam int CORE_CLK_PERIOD_NS = 50;
	localparam int DIV_W = 10;
	localparam logic [DIV_W-1:0] MIN_DIVISOR = 10'h002;
	localparam logic [DIV_W-1:0] MAX_DIVISOR = 10'h3ff;

	// ****************************************
	// Fetch and FIFO sizing
	// ****************************************
	localparam int CONFIG_REG_COUNT = 18;
	localparam int BURST_WORDS = 4;
	localparam logic [1:0] BURST_BEAT_LAST = 2'h3;
	localparam int HALF_FIFO_WORDS = 12;
	localparam int TOTAL_FIFO_WORDS = 24;
	localparam int FIFO_PTR_W = 4;
	localparam int FIFO_CNT_W = 4;
	localparam logic [FIFO_PTR_W-1:0] FIFO_PTR_LAST = 4'hb;
	localparam logic [FIFO_CNT_W-1:0] FIFO_REFILL_LEVEL = 4'h8;
	localparam logic [2:0] UNITS_NIBBLE = 3'h7;
	localparam logic [2:0] UNITS_BYTE = 3'h3;

	// ****************************************
	// Reset values and state types
	// ****************************************
	localparam logic AC_BIAS_RESET = 1'b0;

	typedef enum logic [1:0] {
		T_IDLE = 2'b00,
		T_ACTIVE = 2'b01,
		T_GAP = 2'b10
	} slt_tstate_e;

	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_REQ = 2'b01,
		F_BURST = 2'b10
	} slt_fstate_e;

endpackage

// ---- inc/slt_stream_if.sv ----
// Purpose: Valid/ready word stream between the FIFOs, buffer and formatter.
// Assumes: Source and sink share one clock.
// Notes: A word moves on a cycle with valid and ready both high.
`timescale 1ns/10ps
interface slt_stream_if #(
	parameter int W = 64
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/slt_pair_buffer.sv ----
// Purpose: Two-entry buffer so that a stalled receiver loses no word.
// Assumes: Synchronous active-low reset.
// Notes: Ready toward the source falls only when both entries are full.
`timescale 1ns/10ps
module slt_pair_buffer
	import slt_pkg::*;
#(
	parameter int W = 64
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Streams.
	slt_stream_if.snk up,
	slt_stream_if.src dn
);

	logic [W-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	wire push = up.valid && up.ready;
	wire pop = dn.valid && dn.ready;

	assign up.ready = (count != 2'h2);
	assign dn.valid = (count != 2'h0);
	assign dn.data = mem[rd_ptr];

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= rd_ptr ^ pop;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= up.data;
		end
	end

endmodule

// ---- verilog/slt_timing_fetch.sv ----
// Purpose: STN panel timing generator, frame fetch DMA, FIFOs and pixel formatter.
// Assumes: One 20 MHz core clock; the bus and the configuration share it.
// Notes: Configuration ports stand for the software register set.
// Notes on behaviour
// - Frame sync is high for the whole first line of every frame.
// - Line sync pulses after each full line of pixel data has been shifted out.
// - Pixel data changes at the rising pixel clock edge; the panel samples at the falling one.
// - The low four lines carry the data in single scan and the upper half in dual scan.
// - The high four lines carry the upper nibble in 8-bit single and the lower half in dual scan.
// - AC bias toggles per frame, or once per bias line count line pulses when selected.
// - The pixel clock is the core clock divided by twice the divisor, least divisor 2.
// - Four valid data lines in 4-bit single scan and eight in dual and 8-bit single scan shape each line.
// - A line is width count plus one pixel periods then pulse, delay and blank cycles.
// - The fetch DMA requests four-word bursts when a FIFO has room and holds the bus.
// - Two FIFOs of twelve words each; both used in dual scan, only the upper in single.
// - The configuration set steers the timing generator, the fetch DMA and the formatter.
`timescale 1ns/10ps
module slt_timing_fetch
	import slt_pkg::*;
#(
	parameter int LW_W = 11,
	parameter int LC_W = 10,
	parameter int GAP_W = 8,
	parameter int FW_W = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Configuration.
	input wire logic enable,
	input wire logic [1:0] scan_mode,
	input wire logic [DIV_W-1:0] pixel_clock_divisor,
	input wire logic [LW_W-1:0] line_width_count,
	input wire logic [LC_W-1:0] line_count,
	input wire logic [GAP_W-1:0] line_pulse_width,
	input wire logic [GAP_W-1:0] line_to_pixel_delay,
	input wire logic [GAP_W-1:0] line_blank_count,
	input wire logic bias_toggle_select,
	input wire logic [7:0] bias_line_count,
	input wire logic [31:0] frame_base_upper,
	input wire logic [31:0] frame_base_lower,
	input wire logic [FW_W-1:0] frame_words,
	// Memory fetch bus.
	output logic fetch_req,
	output logic [31:0] fetch_addr,
	output logic fetch_lock,
	input wire logic fetch_grant,
	input wire logic fetch_data_valid,
	input wire logic [31:0] fetch_data,
	// Panel pins.
	output logic frame_sync,
	output logic line_sync,
	output logic pixel_clock,
	output logic ac_bias,
	output logic [3:0] low_pixel_lines,
	output logic [3:0] high_pixel_lines,
	// Status.
	output logic pixel_underrun
);

	// ****************************************
	// Parameter checks
	// ****************************************
	if (LW_W < 1 || LC_W < 1 || GAP_W < 1 || FW_W < 3) begin : g_bad_width
		$error("slt_timing_fetch: counter widths too small");
	end

	// ****************************************
	// Configuration decode
	// ****************************************
	wire dual = (scan_mode == SCAN_DUAL4);
	wire wide8 = (scan_mode == SCAN_SINGLE8);
	wire [DIV_W-1:0] div_eff = (pixel_clock_divisor < MIN_DIVISOR) ? MIN_DIVISOR :
		pixel_clock_divisor;
	wire [GAP_W-1:0] pulse_len = (line_pulse_width == '0) ? GAP_W'(1) : line_pulse_width;
	wire [GAP_W+1:0] gap_total = GAP_W'(0) + {2'b00, pulse_len} + {2'b00, line_to_pixel_delay}
		+ {2'b00, line_blank_count};
	wire [7:0] bias_eff = (bias_line_count == 8'h00) ? 8'h01 : bias_line_count;

	// ****************************************
	// Timing generator
	// ****************************************
	slt_tstate_e tstate;
	logic [DIV_W-1:0] div_cnt;
	logic [LW_W:0] pix_cnt;
	logic [GAP_W+1:0] gap_cnt;
	logic [LC_W-1:0] line_idx;
	logic [7:0] bias_cnt;

	wire active = (tstate == T_ACTIVE);
	wire div_done = (div_cnt == div_eff - DIV_W'(1));
	wire pix_rise = active && div_done && !pixel_clock;
	wire pix_fall = active && div_done && pixel_clock;
	wire line_done = pix_fall && (pix_cnt == {1'b0, line_width_count} + (LW_W+1)'(1));
	wire gap_done = (tstate == T_GAP) && (gap_cnt == gap_total - (GAP_W+2)'(1));
	wire last_line = (line_idx == line_count);
	wire frame_start = (tstate == T_IDLE) || (gap_done && last_line);
	wire bias_wrap = (bias_cnt + 8'h01 >= bias_eff);
	wire [GAP_W+1:0] next_gap_cnt = gap_cnt + (GAP_W+2)'(1);

	always_ff @(posedge core_clk) begin
		if (!reset_n || !enable) begin
			tstate <= T_IDLE;
			div_cnt <= '0;
			pix_cnt <= '0;
			gap_cnt <= '0;
			line_idx <= '0;
		end else begin
			unique case (tstate)
				T_IDLE: begin
					tstate <= T_ACTIVE;
				end
				T_ACTIVE: begin
					div_cnt <= div_done ? '0 : div_cnt + DIV_W'(1);
					if (pix_rise) begin
						pix_cnt <= pix_cnt + (LW_W+1)'(1);
					end
					if (line_done) begin
						tstate <= T_GAP;
						gap_cnt <= '0;
					end
				end
				T_GAP: begin
					gap_cnt <= next_gap_cnt;
					if (gap_done) begin
						tstate <= T_ACTIVE;
						pix_cnt <= '0;
						div_cnt <= '0;
						line_idx <= last_line ? '0 : line_idx + LC_W'(1);
					end
				end
				default: begin
					tstate <= T_IDLE;
				end
			endcase
		end
	end

	// Panel control outputs.
	always_ff @(posedge core_clk) begin
		if (!reset_n || !enable) begin
			pixel_clock <= 1'b0;
			line_sync <= 1'b0;
			frame_sync <= 1'b0;
		end else begin
			if (active && div_done) begin
				pixel_clock <= ~pixel_clock;
			end
			if (line_done) begin
				line_sync <= 1'b1;
			end else if (tstate == T_GAP) begin
				line_sync <= (next_gap_cnt < {2'b00, pulse_len});
			end
			if (frame_start) begin
				frame_sync <= 1'b1;
			end else if (gap_done) begin
				frame_sync <= 1'b0;
			end
		end
	end

	// AC bias toggling.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ac_bias <= AC_BIAS_RESET;
			bias_cnt <= 8'h00;
		end else if (enable) begin
			if (frame_start) begin
				bias_cnt <= 8'h00;
				if (!bias_toggle_select) begin
					ac_bias <= ~ac_bias;
				end
			end else if (line_done && bias_toggle_select) begin
				bias_cnt <= bias_wrap ? 8'h00 : bias_cnt + 8'h01;
				if (bias_wrap) begin
					ac_bias <= ~ac_bias;
				end
			end
		end
	end

	// ****************************************
	// Frame fetch DMA and half FIFOs
	// ****************************************
	slt_fstate_e fstate;
	logic target;
	logic [1:0] beat;
	logic [FIFO_CNT_W-1:0] fifo_count [2];
	logic [FW_W-1:0] word_off [2];
	logic [31:0] fifo_head [2];
	wire [31:0] half_base [2];
	logic [1:0] pop_half;

	slt_stream_if #(.W(64)) fmt_in ();
	slt_stream_if #(.W(64)) fmt_out ();

	assign half_base[0] = frame_base_upper;
	assign half_base[1] = frame_base_lower;
	wire need_up = (fifo_count[0] <= FIFO_REFILL_LEVEL);
	wire need_lo = dual && (fifo_count[1] <= FIFO_REFILL_LEVEL);
	wire pick = need_lo && (!need_up || fifo_count[1] < fifo_count[0]);
	wire word_in = (fstate == F_BURST) && fetch_data_valid;
	wire take = fmt_in.valid && fmt_in.ready;

	for (genvar h = 0; h < 2; h++) begin : g_half
		logic [31:0] mem [HALF_FIFO_WORDS];
		logic [FIFO_PTR_W-1:0] wr_ptr;
		logic [FIFO_PTR_W-1:0] rd_ptr;
		wire push = word_in && (target == h);
		wire adv = (fstate == F_REQ) && fetch_grant && (target == h);
		wire [FW_W-1:0] next_off = word_off[h] + FW_W'(BURST_WORDS);

		assign pop_half[h] = take && (h == 0 || dual);
		assign fifo_head[h] = mem[rd_ptr];

		always_ff @(posedge core_clk) begin
			if (!reset_n) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
				fifo_count[h] <= '0;
				word_off[h] <= '0;
			end else begin
				if (push) begin
					wr_ptr <= (wr_ptr == FIFO_PTR_LAST) ? '0 : wr_ptr + FIFO_PTR_W'(1);
				end
				if (pop_half[h]) begin
					rd_ptr <= (rd_ptr == FIFO_PTR_LAST) ? '0 : rd_ptr + FIFO_PTR_W'(1);
				end
				fifo_count[h] <= fifo_count[h] + FIFO_CNT_W'(push) - FIFO_CNT_W'(pop_half[h]);
				if (adv) begin
					word_off[h] <= (next_off >= frame_words) ? '0 : next_off;
				end
			end
		end

		always_ff @(posedge core_clk) begin
			if (push) begin
				mem[wr_ptr] <= fetch_data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			fstate <= F_IDLE;
			fetch_req <= 1'b0;
			fetch_lock <= 1'b0;
			fetch_addr <= 32'h0;
			target <= 1'b0;
			beat <= 2'h0;
		end else begin
			unique case (fstate)
				F_IDLE: begin
					if (enable && (need_up || need_lo)) begin
						fstate <= F_REQ;
						fetch_req <= 1'b1;
						target <= pick;
						fetch_addr <= half_base[pick] + 32'({word_off[pick], 2'b00});
					end
				end
				F_REQ: begin
					if (fetch_grant) begin
						fstate <= F_BURST;
						fetch_req <= 1'b0;
						fetch_lock <= 1'b1;
						beat <= 2'h0;
					end
				end
				F_BURST: begin
					if (fetch_data_valid) begin
						beat <= beat + 2'h1;
						if (beat == BURST_BEAT_LAST) begin
							fstate <= F_IDLE;
							fetch_lock <= 1'b0;
						end
					end
				end
				default: begin
					fstate <= F_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pixel formatter
	// ****************************************
	logic [63:0] shreg;
	logic [3:0] units_left;
	wire empty = (units_left == 4'h0);

	assign fmt_in.valid = (fifo_count[0] != '0) && (!dual || fifo_count[1] != '0);
	assign fmt_in.data = {dual ? fifo_head[1] : 32'h0, fifo_head[0]};
	assign fmt_out.ready = empty && !pix_rise;

	slt_pair_buffer #(.W(64)) u_pair_buffer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.up(fmt_in),
		.dn(fmt_out)
	);

	wire [31:0] next_upper = wide8 ? {shreg[23:0], 8'h00} : {shreg[27:0], 4'h0};
	wire [31:0] next_lower = {shreg[59:32], 4'h0};
	wire [3:0] next_low_lines = wide8 ? shreg[27:24] : shreg[31:28];
	wire [3:0] next_high_lines = wide8 ? shreg[31:28] : (dual ? shreg[63:60] : 4'h0);

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			shreg <= 64'h0;
			units_left <= 4'h0;
			low_pixel_lines <= 4'h0;
			high_pixel_lines <= 4'h0;
			pixel_underrun <= 1'b0;
		end else begin
			pixel_underrun <= pix_rise && empty;
			if (pix_rise) begin
				low_pixel_lines <= empty ? 4'h0 : next_low_lines;
				high_pixel_lines <= empty ? 4'h0 : next_high_lines;
				if (!empty) begin
					shreg <= {next_lower, next_upper};
					units_left <= units_left - 4'h1;
				end
			end else if (fmt_out.valid && fmt_out.ready) begin
				shreg <= fmt_out.data;
				units_left <= {1'b0, wide8 ? UNITS_BYTE : UNITS_NIBBLE} + 4'h1;
			end
		end
	end

endmodule

// ---- bench/slt_properties.sv ----
// Purpose: Port assertions of the timing and fetch block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Some figures hold for divisor 2 or pulse width 2 only.
`timescale 1ns/10ps
module slt_props
	import slt_pkg::*;
#(
	parameter int GAP_W = 8
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Configuration.
	input wire logic bias_toggle_select,
	input wire logic [DIV_W-1:0] pixel_clock_divisor,
	input wire logic [GAP_W-1:0] line_pulse_width,
	// Fetch bus.
	input wire logic fetch_req,
	input wire logic fetch_grant,
	input wire logic fetch_lock,
	input wire logic fetch_data_valid,
	// Panel pins.
	input wire logic frame_sync,
	input wire logic line_sync,
	input wire logic pixel_clock,
	input wire logic ac_bias,
	input wire logic [3:0] low_pixel_lines,
	input wire logic [3:0] high_pixel_lines
);
	logic [2:0] beats;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	always_ff @(posedge core_clk) begin
		if (!reset_n || !fetch_lock)
			beats <= 3'h0;
		else if (fetch_data_valid)
			beats <= beats + 3'h1;
	end
	property p_lock;
		fetch_req && fetch_grant |=> fetch_lock && !fetch_req;
	endproperty
	a_lock: assert property (p_lock) else $error("no lock");
	property p_burst;
		$fell(fetch_lock) |-> $past(beats) == 3'h3 && $past(fetch_data_valid);
	endproperty
	a_burst: assert property (p_burst) else $error("burst length");
	property p_gap;
		line_sync |-> !pixel_clock;
	endproperty
	a_gap: assert property (p_gap) else $error("clock in gap");
	property p_div2;
		$rose(pixel_clock) && pixel_clock_divisor == 2 |-> pixel_clock [*2] ##1 !pixel_clock;
	endproperty
	a_div2: assert property (p_div2) else $error("clock period");
	property p_data;
		$changed({high_pixel_lines, low_pixel_lines}) |-> $rose(pixel_clock);
	endproperty
	a_data: assert property (p_data) else $error("data off edge");
	property p_pulse;
		$rose(line_sync) && line_pulse_width == 2 |-> ##1 line_sync ##1 !line_sync;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width");
	property p_bias;
		!bias_toggle_select && $changed(ac_bias) |-> $rose(frame_sync);
	endproperty
	a_bias: assert property (p_bias) else $error("bias toggle");
	property p_frame;
		$rose(frame_sync) |-> !line_sync && !pixel_clock;
	endproperty
	a_frame: assert property (p_frame) else $error("frame start");
endmodule
bind slt_timing_fetch slt_props #(.GAP_W(GAP_W)) u_props (
	.core_clk(core_clk), .reset_n(reset_n), .bias_toggle_select(bias_toggle_select),
	.pixel_clock_divisor(pixel_clock_divisor), .line_pulse_width(line_pulse_width),
	.fetch_req(fetch_req), .fetch_grant(fetch_grant), .fetch_lock(fetch_lock),
	.fetch_data_valid(fetch_data_valid), .frame_sync(frame_sync), .line_sync(line_sync),
	.pixel_clock(pixel_clock), .ac_bias(ac_bias), .low_pixel_lines(low_pixel_lines),
	.high_pixel_lines(high_pixel_lines)
);

// ---- bench/slt_mem_model.sv ----
// Purpose: Memory side of the fetch bus.
// Assumes: Same clock as the block.
// Notes: A word reads as the inverse of its byte address.
`timescale 1ns/10ps
module slt_mem_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Mode: 0 prompt, 1 slow with stalls, 2 never grants.
	input wire logic [1:0] slow,
	// Fetch bus.
	input wire logic fetch_req,
	input wire logic [31:0] fetch_addr,
	output logic fetch_grant,
	output logic fetch_data_valid,
	output logic [31:0] fetch_data
);
	logic act, stall;
	logic [1:0] w;
	logic [2:0] n;
	logic [31:0] base;
	int k;
	always @(posedge core_clk) begin
		fetch_grant <= 0;
		fetch_data_valid <= 0;
		fetch_data <= ~fetch_data;
		stall <= ~stall;
		if (!reset_n) begin
			act <= 0;
			w <= 0;
			stall <= 0;
			fetch_data <= 0;
		end else if (act) begin
			k = n + fetch_data_valid;
			n <= 3'(k);
			if (k == 4)
				act <= 0;
			else if (!(slow[0] && stall)) begin
				fetch_data_valid <= 1;
				fetch_data <= ~(base + 32'(4 * k));
			end
		end else if (fetch_grant) begin
			act <= 1;
			n <= 0;
			base <= fetch_addr;
			fetch_data_valid <= 1;
			fetch_data <= ~fetch_addr;
		end else if (fetch_req && !slow[1]) begin
			w <= w + 2'h1;
			if (w == 3 || !slow[0])
				fetch_grant <= 1;
		end
	end
endmodule

// ---- bench/slt_timing_fetch_tb_top.sv ----
// Purpose: Self-checking bench of the timing and fetch block.
// Assumes: 50 ns clock and the memory model on the fetch bus.
// Notes: Expected pixels follow from base addresses and word order.
`timescale 1ns/10ps
module slt_timing_fetch_tb_top
	import slt_pkg::*;
;
	logic clk = 0, rst_n = 0, en = 0, bsel = 0, pp, pf, pl, pa;
	logic [1:0] mode = 0, slow = 0;
	logic [DIV_W-1:0] div = 2;
	logic [10:0] lw = 15;
	logic [9:0] lc = 3;
	logic [7:0] pw = 2, dl = 0, bk = 0, blc = 2, e;
	logic [31:0] bu = 0, bl = 0, fa, fd, w, x;
	logic [15:0] fw = 8;
	logic rq, lk, gt, dv, fs, ls, pk, ac, un;
	logic [3:0] lo, hi;
	int mismatches = 0, num_checks = 0, seed = 21445, cyc = 0;
	int s, n, bi, bj, pc, pcy, lines, lp, und_n, frames;
	slt_timing_fetch uut (
		.core_clk(clk), .reset_n(rst_n), .enable(en), .scan_mode(mode),
		.pixel_clock_divisor(div), .line_width_count(lw), .line_count(lc),
		.line_pulse_width(pw), .line_to_pixel_delay(dl), .line_blank_count(bk),
		.bias_toggle_select(bsel), .bias_line_count(blc), .frame_base_upper(bu),
		.frame_base_lower(bl), .frame_words(fw), .fetch_req(rq), .fetch_addr(fa),
		.fetch_lock(lk), .fetch_grant(gt), .fetch_data_valid(dv), .fetch_data(fd),
		.frame_sync(fs), .line_sync(ls), .pixel_clock(pk), .ac_bias(ac),
		.low_pixel_lines(lo), .high_pixel_lines(hi), .pixel_underrun(un)
	);
	slt_mem_model mem (.core_clk(clk), .reset_n(rst_n), .slow(slow), .fetch_req(rq),
		.fetch_addr(fa), .fetch_grant(gt), .fetch_data_valid(dv), .fetch_data(fd));
	always #25 clk = ~clk;
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [31:0] wd(logic [31:0] b, int i);
		return ~(b + 32'(4 * (i % fw)));
	endfunction
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	// Reference model sampled at the falling edge, where outputs are settled.
	always @(negedge clk) begin
		if (rst_n && en) begin
			pcy++;
			if (rq && gt && mode == 2 && fa >= bl) begin
				chk(fa, bl + 4 * ((4 * bj) % fw));
				bj++;
			end else if (rq && gt) begin
				chk(fa, bu + 4 * ((4 * bi) % fw));
				bi++;
			end
			if (pk && !pp) begin
				if (pc > 0) chk(pcy, 2 * div);
				pcy = 0;
				pc++;
				w = wd(bu, n / (mode == 1 ? 4 : 8));
				x = wd(bl, n / 8);
				case (mode)
					1: e = w[8 * (3 - n % 4) +: 8];
					2: e = {x[4 * (7 - n % 8) +: 4], w[4 * (7 - n % 8) +: 4]};
					default: e = {4'h0, w[4 * (7 - n % 8) +: 4]};
				endcase
				// An underrun drives zeros and consumes no unit of the stream.
				if (un) begin
					und_n += (n > 0);
					e = 8'h00;
				end else begin
					n++;
				end
				chk({hi, lo}, e);
			end
			if (ls && !pl) begin
				chk(pc, lw + 1);
				chk(fs, lines == 0);
				lines++;
				lp++;
				pc = 0;
			end
			if (ac !== pa) begin
				chk(bsel ? lp == blc : fs && !pf, 1);
				lp = 0;
			end
			if (fs && !pf) begin
				if (frames > 0) chk(lines, lc + 1);
				lines = 0;
				lp = 0;
				frames++;
			end
		end
		pp = pk;
		pf = fs;
		pl = ls;
		pa = ac;
	end
	initial begin
		for (s = 0; s < 4; s++) begin
			@(posedge clk);
			rst_n <= 0;
			en <= 0;
			mode <= 2'(s == 3 ? 0 : s);
			div <= s == 1 ? 10'h003 : 10'h002;
			slow <= s == 1 ? 2'h1 : {s == 3, 1'b0};
			bsel <= s inside {1, 2};
			blc <= s == 1 ? 8'h03 : 8'h02;
			pw <= s == 0 ? 8'h02 : 8'(1 + {$random(seed)} % 3);
			dl <= 8'({$random(seed)} % 6);
			bk <= 8'({$random(seed)} % 6);
			bu <= {$random(seed)} & 32'h00007ff0;
			bl <= {$random(seed)} & 32'h0000fff0 | 32'h00010000;
			fw <= s == 1 ? 16'h0010 : 16'h0008;
			repeat (8) @(posedge clk);
			{n, bi, bj, pc, lines, lp, und_n, frames} = '0;
			rst_n <= 1;
			en <= 1;
			repeat (1500) @(posedge clk);
			chk(und_n, 0);
			chk(n == 0, slow == 2);
			$display("test %0d done", s);
		end
		finish_test();
	end
endmodule
